// ### src/usbrg_top.sv
// baud rate generator with source select, fractional divide and modem pins
`timescale 1ns/10ps
module usbrg_top (
    input wire logic clk_sys, // master clock
    input wire logic reset, // synchronous reset, active high
    input wire logic clk_en, // peripheral clock enable, freezes state when low
    input wire logic [1:0] clock_source_select, // source select field
    input wire logic sync_mode, // one selects synchronous mode
    input wire logic over, // oversampling select
    input wire logic [3:0] channel_mode, // channel operating mode
    input wire logic [usbrg_pkg::USBRG_CD_W-1:0] clock_divisor, // integer divisor
    input wire logic [usbrg_pkg::USBRG_FP_W-1:0] fractional_part, // eighths
    input wire logic sck_in, // serial clock pin input
    input wire logic rx_ready, // receiver can accept data, steers request-to-send
    input wire logic dtr_assert, // software request for terminal ready
    input wire logic modem_present, // instance carries modem pins
    input wire logic ring_indicator_in_n, // ring indicator, active low
    input wire logic dsr_in_n, // data set ready, active low
    input wire logic carrier_detect_in_n, // carrier detect, active low
    input wire logic cts_in_n, // clear to send, active low
    output logic sample_tick, // one pulse per oversampling clock
    output logic baud_tick, // one pulse per bit period
    output logic baud_clk, // synchronous serial clock level
    output logic tx_allowed, // clear-to-send permits transmission
    output logic rts_out_n, // request to send, active low
    output logic dtr_out_n, // terminal ready, active low
    output logic ring_flag, // ring seen
    output logic dsr_flag, // data set ready seen
    output logic carrier_flag, // carrier seen
    output logic cts_flag // clear to send seen
);
    import usbrg_pkg::*;

    usbrg_state_t st;
    usbrg_state_t next_st;
    logic src_tick;
    logic div_tick;
    logic frac_on;
    logic [USBRG_CD_W-1:0] period_last;
    logic [USBRG_CD_W-1:0] half_last;
    logic [USBRG_FP_W:0] acc_sum;
    logic hwhs;
    logic [3:0] ovs_last;
    logic [3:0] ovs_mid;

    // ==========================================================
    // combinational next state
    always_comb begin
        next_st = st;

        // ==========================================================
        // pin synchronisers
        // only the last stage of each chain is read by logic, except sck, whose last two stages form the edge detect
        next_st.sck_sync = {st.sck_sync[1:0], sck_in};
        next_st.cts_sync = {st.cts_sync[1:0], cts_in_n};
        next_st.ri_sync = {st.ri_sync[0], ring_indicator_in_n};
        next_st.dsr_sync = {st.dsr_sync[0], dsr_in_n};
        next_st.dcd_sync = {st.dcd_sync[0], carrier_detect_in_n};

        // ==========================================================
        // source clock
        // source clock select
        next_st.prediv_cnt = (st.prediv_cnt == USBRG_PREDIV_LAST) ? '0 : st.prediv_cnt + 3'h1;
        case (clock_source_select)
            USBRG_SRC_MCK: src_tick = 1'b1;
            USBRG_SRC_DIV: src_tick = (st.prediv_cnt == USBRG_PREDIV_LAST);
            // rising edge taken from the synchronised pin, never the raw pin
            USBRG_SRC_EXT: src_tick = st.sck_sync[1] & ~st.sck_sync[2];
            default: src_tick = 1'b1;
        endcase

        // ==========================================================
        // fractional accumulator
        // fraction only in normal mode, async only
        frac_on = (fractional_part != USBRG_FP_ZERO) && (channel_mode == USBRG_MODE_NORMAL)
            && !sync_mode;
        // stretch period by one when accumulator overflows
        acc_sum = {1'b0, st.frac_acc} + {1'b0, fractional_part};
        // the carry lengthens the period that follows, so any eight periods hold all carries
        period_last = clock_divisor - USBRG_CD_ONE + USBRG_CD_W'(st.extra_cycle);
        half_last = (clock_divisor >> 1) - USBRG_CD_ONE;
        ovs_last = over ? USBRG_OVS8_LAST : USBRG_OVS16_LAST;
        ovs_mid = over ? USBRG_OVS8_MID : USBRG_OVS16_MID;

        // ==========================================================
        // integer divider
        div_tick = 1'b0;
        next_st.sample_tick = 1'b0;
        next_st.baud_tick = 1'b0;
        if (clock_divisor == USBRG_CD_OFF) begin
            next_st.div_cnt = '0;
            next_st.ovs_cnt = '0;
            next_st.baud_clk = 1'b0;
            next_st.phase = USBRG_TOGGLE_LOW;
        end else if (sync_mode && clock_source_select == USBRG_SRC_EXT) begin
            // external clock undivided in synchronous mode
            next_st.baud_tick = src_tick;
            next_st.baud_clk = st.sck_sync[2];
        end else if (src_tick) begin
            if (clock_divisor == USBRG_CD_BYPASS) begin
                div_tick = 1'b1;
            end else if (st.div_cnt >= period_last) begin
                div_tick = 1'b1;
                next_st.div_cnt = '0;
            end else begin
                next_st.div_cnt = st.div_cnt + USBRG_CD_ONE;
            end
            if (div_tick) begin
                next_st.frac_acc = frac_on ? acc_sum[USBRG_FP_W-1:0] : USBRG_FP_ZERO;
                next_st.extra_cycle = frac_on & acc_sum[USBRG_FP_W];
            end
            if (sync_mode) begin
                // bit clock toggles mid period
                // odd divisors above one stay high one source tick longer: one edge cannot split a tick
                next_st.baud_tick = div_tick;
                case (st.phase)
                    USBRG_TOGGLE_LOW: begin
                        if (!div_tick && clock_divisor > USBRG_CD_BYPASS
                            && st.div_cnt == half_last) begin
                            next_st.baud_clk = 1'b1;
                            next_st.phase = USBRG_TOGGLE_HIGH;
                        end else if (div_tick) begin
                            next_st.baud_clk = 1'b0;
                        end
                    end
                    USBRG_TOGGLE_HIGH: begin
                        if (div_tick) begin
                            next_st.baud_clk = 1'b0;
                            next_st.phase = USBRG_TOGGLE_LOW;
                        end
                    end
                    default: begin
                        next_st.baud_clk = 1'b0;
                        next_st.phase = USBRG_TOGGLE_LOW;
                    end
                endcase
            end else if (div_tick) begin
                // sampling clock then divide by sixteen or eight
                next_st.sample_tick = 1'b1;
                if (st.ovs_cnt >= ovs_last) begin
                    next_st.ovs_cnt = '0;
                    next_st.baud_tick = 1'b1;
                    next_st.baud_clk = 1'b0;
                end else begin
                    next_st.ovs_cnt = st.ovs_cnt + 4'h1;
                    if (st.ovs_cnt == ovs_mid) begin
                        next_st.baud_clk = 1'b1;
                    end
                end
            end
        end

        // ==========================================================
        // modem and handshake pins
        // request-to-send from receiver readiness
        hwhs = (channel_mode == USBRG_MODE_HWHS);
        next_st.rts_n = hwhs ? ~rx_ready : 1'b1;
        // absent modem pins inert, all active low
        next_st.dtr_n = (modem_present && channel_mode == USBRG_MODE_MODEM) ? ~dtr_assert : 1'b1;
        next_st.ri_flag = modem_present & ~st.ri_sync[1];
        next_st.dsr_flag = modem_present & ~st.dsr_sync[1];
        next_st.dcd_flag = modem_present & ~st.dcd_sync[1];
        next_st.cts_flag = ~st.cts_sync[2];
        next_st.tx_ok = ~hwhs | ~st.cts_sync[2];
    end

    // ==========================================================
    // state register
    // clock stop freezes state
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st <= '0;
            st.rts_n <= 1'b1;
            st.dtr_n <= 1'b1;
            // active low pins rest high, so no false flag follows reset
            st.cts_sync <= USBRG_SYNC3_IDLE;
            st.ri_sync <= USBRG_SYNC2_IDLE;
            st.dsr_sync <= USBRG_SYNC2_IDLE;
            st.dcd_sync <= USBRG_SYNC2_IDLE;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs, each straight from the state register
    assign sample_tick = st.sample_tick;
    assign baud_tick = st.baud_tick;
    assign baud_clk = st.baud_clk;

    assign tx_allowed = st.tx_ok;
    assign rts_out_n = st.rts_n;
    assign dtr_out_n = st.dtr_n;
    assign ring_flag = st.ri_flag;
    assign dsr_flag = st.dsr_flag;
    assign carrier_flag = st.dcd_flag;
    assign cts_flag = st.cts_flag;
endmodule

// ### src/usbrg_pkg.sv
// constants and types for the serial baud rate generator
package usbrg_pkg;
    // clock_source_select encodings
    localparam logic [1:0] USBRG_SRC_MCK = 2'h0;
    localparam logic [1:0] USBRG_SRC_DIV = 2'h1;
    localparam logic [1:0] USBRG_SRC_EXT = 2'h3;
    // master clock predivider factor
    localparam int USBRG_PREDIV = 8;
    localparam logic [2:0] USBRG_PREDIV_LAST = 3'(USBRG_PREDIV - 1);
    localparam int USBRG_CD_W = 16;
    localparam int USBRG_FP_W = 3;
    localparam logic [USBRG_CD_W-1:0] USBRG_CD_OFF = 16'h0000;
    localparam logic [USBRG_CD_W-1:0] USBRG_CD_BYPASS = 16'h0001;
    localparam logic [USBRG_CD_W-1:0] USBRG_CD_ONE = 16'h0001;
    // oversampling divisions: sixteen or eight samples per bit
    localparam logic [3:0] USBRG_OVS16_LAST = 4'hf;
    localparam logic [3:0] USBRG_OVS8_LAST = 4'h7;
    // sampling count at which the asynchronous bit clock level rises
    localparam logic [3:0] USBRG_OVS16_MID = 4'h7;
    localparam logic [3:0] USBRG_OVS8_MID = 4'h3;
    // channel mode values for normal, hardware handshake and modem operation
    localparam logic [3:0] USBRG_MODE_NORMAL = 4'h0;
    localparam logic [3:0] USBRG_MODE_HWHS = 4'h2;
    localparam logic [3:0] USBRG_MODE_MODEM = 4'h3;
    localparam logic [USBRG_FP_W-1:0] USBRG_FP_ZERO = 3'h0;
    // idle level of the active low pin synchronisers
    localparam logic [2:0] USBRG_SYNC3_IDLE = 3'h7;
    localparam logic [1:0] USBRG_SYNC2_IDLE = 2'h3;

    typedef enum logic [1:0] {USBRG_TOGGLE_LOW, USBRG_TOGGLE_HIGH} usbrg_phase_t;

    typedef struct packed {
        logic [2:0] prediv_cnt;
        logic [2:0] sck_sync;
        logic [USBRG_CD_W-1:0] div_cnt;
        logic [USBRG_FP_W-1:0] frac_acc;
        logic extra_cycle;
        logic [3:0] ovs_cnt;
        logic sample_tick;
        logic baud_tick;
        logic baud_clk;
        usbrg_phase_t phase;
        logic [2:0] cts_sync;
        logic [1:0] ri_sync;
        logic [1:0] dsr_sync;
        logic [1:0] dcd_sync;
        logic rts_n;
        logic dtr_n;
        logic ri_flag;
        logic dsr_flag;
        logic dcd_flag;
        logic cts_flag;
        logic tx_ok;
    } usbrg_state_t;
endpackage

// ### verification/usbrg_asserts.sv
// port checker for the baud rate generator
`timescale 1ns/10ps
module usbrg_asserts
    import usbrg_pkg::*;
(
    input wire logic clk_sys, // clock
    input wire logic reset, // reset
    input wire logic clk_en, // enable
    input wire logic [1:0] clock_source_select, // source
    input wire logic sync_mode, // sync
    input wire logic [3:0] channel_mode, // mode
    input wire logic [15:0] clock_divisor, // divisor
    input wire logic [2:0] fractional_part, // eighths
    input wire logic rx_ready, // rx room
    input wire logic dtr_assert, // dtr req
    input wire logic modem_present, // pins
    input wire logic ring_indicator_in_n, // ring pin
    input wire logic sample_tick, // sample
    input wire logic baud_tick, // bit
    input wire logic baud_clk, // bit clk
    input wire logic tx_allowed, // cts ok
    input wire logic rts_out_n, // rts
    input wire logic dtr_out_n, // dtr
    input wire logic ring_flag, // ring
    input wire logic dsr_flag, // dsr
    input wire logic carrier_flag, // dcd
    input wire logic cts_flag // cts
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic en_a = clk_en && !sync_mode;
    wire logic a2 = en_a && clock_source_select == USBRG_SRC_MCK && clock_divisor == 16'h0002
        && fractional_part == USBRG_FP_ZERO;
    wire logic cd0 = en_a && clock_divisor == USBRG_CD_OFF;
    wire logic s4 = clk_en && sync_mode && clock_source_select == USBRG_SRC_MCK
        && clock_divisor == 16'h0004;
    reset_idle_a: assert property (disable iff (1'b0) reset |=> !sample_tick && !baud_tick
        && !baud_clk && rts_out_n && dtr_out_n) else $error("outputs busy after reset");
    zero_div_a: assert property (cd0[*3] |-> !sample_tick && !baud_tick)
        else $error("tick with zero divisor");
    freeze_hold_a: assert property (!clk_en |=> $stable({sample_tick, baud_tick, baud_clk,
        dtr_out_n, cts_flag})) else $error("state moved while frozen");
    no_modem_a: assert property ((!modem_present && clk_en)[*2] |-> !ring_flag
        && !dsr_flag && !carrier_flag) else $error("modem flag without pins");
    dtr_drive_a: assert property ((modem_present && dtr_assert && clk_en
        && channel_mode == USBRG_MODE_MODEM)[*2] |-> !dtr_out_n) else $error("dtr idle");
    rts_drive_a: assert property ((rx_ready && clk_en
        && channel_mode == USBRG_MODE_HWHS)[*2] |-> !rts_out_n) else $error("rts idle");
    cts_gate_a: assert property ((channel_mode == USBRG_MODE_HWHS)[*2] |-> tx_allowed == cts_flag)
        else $error("tx not gated by cts");
    tx_free_a: assert property (clk_en && channel_mode != USBRG_MODE_HWHS |=> tx_allowed)
        else $error("tx blocked without handshake");
    sync_duty_a: assert property (s4[*8] ##0 $rose(baud_clk) |-> !$past(baud_clk, 2)
        && $past(baud_clk, 3) && $past(baud_clk, 4)) else $error("sync clock duty wrong");
    ring_seen_a: assert property ((modem_present && clk_en && !ring_indicator_in_n)[*4]
        |-> ring_flag) else $error("ring flag missing");
    tick_space_a: assert property (a2[*8] ##0 sample_tick |-> $past(sample_tick, 2)
        && !$past(sample_tick)) else $error("sample spacing wrong");
    cover property (a2 && baud_tick);
    cover property (!clk_en && baud_tick);
    cover property (!dtr_out_n && !rts_out_n);
endmodule
bind usbrg_top usbrg_asserts u_chk (.clk_sys, .reset, .clk_en, .clock_source_select, .sync_mode,
    .channel_mode, .clock_divisor, .fractional_part, .rx_ready, .dtr_assert, .modem_present,
    .ring_indicator_in_n,
    .sample_tick, .baud_tick, .baud_clk, .tx_allowed, .rts_out_n, .dtr_out_n, .ring_flag,
    .dsr_flag, .carrier_flag, .cts_flag);

// ### verification/usbrg_remote.sv
// remote modem model: serial clock source and modem status pins
`timescale 1ns/10ps
module usbrg_remote (
    input wire logic clk_sys, // master clock
    input wire logic sck_run, // clock runs only in frames
    output logic sck_in, // serial clock
    output logic [3:0] modem_n // ring, dsr, carrier, cts, active low
);
    int cnt = 0;
    // no interrupt line leaves the block, so no controller sensitivity to keep
    initial {sck_in, modem_n} = 5'h0f;
    // phases of five master periods, ten times slower
    always @(negedge clk_sys) begin
        cnt <= sck_run ? (cnt + 1) % 5 : 0;
        if (sck_run && cnt == 4) sck_in <= ~sck_in;
        if ($urandom_range(0, 15) == 0) modem_n <= 4'($urandom);
    end
endmodule

// ### verification/usbrg_top_tb.sv
// self-checking bench: bit period measured in enabled cycles
`timescale 1ns/10ps
module usbrg_top_tb;
    import usbrg_pkg::*;
    logic clk_sys, reset, clk_en, sync_mode, over, rx_ready, dtr_assert, modem_present;
    logic [1:0] clock_source_select;
    logic [3:0] channel_mode, modem_n;
    logic [15:0] clock_divisor;
    logic [2:0] fractional_part;
    logic sck_in, sck_run, gate, sample_tick, baud_tick, baud_clk, tx_allowed, rts_out_n;
    logic dtr_out_n, ring_flag, dsr_flag, carrier_flag, cts_flag;
    int error_cnt = 0, compares = 0, gap = 0, seen = 0, cd, fp, ov;
    int exp_q[$];
    usbrg_top dut (.clk_sys, .reset, .clk_en, .clock_source_select, .sync_mode, .over,
        .channel_mode, .clock_divisor, .fractional_part, .sck_in, .rx_ready, .dtr_assert,
        .modem_present, .ring_indicator_in_n(modem_n[3]), .dsr_in_n(modem_n[2]),
        .carrier_detect_in_n(modem_n[1]), .cts_in_n(modem_n[0]), .sample_tick, .baud_tick,
        .baud_clk, .tx_allowed, .rts_out_n, .dtr_out_n, .ring_flag, .dsr_flag, .carrier_flag,
        .cts_flag);
    usbrg_remote remote (.clk_sys, .sck_run, .sck_in, .modem_n);
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            error_cnt++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, want);
        end
    endtask
    task automatic summarize();
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic run(input logic [1:0] s, input logic sy, ov, input logic [3:0] m,
                       input int d, f, per, n, input logic g);
        @(negedge clk_sys);
        {clock_source_select, sync_mode, over, channel_mode, gate} = {s, sy, ov, m, g};
        {clock_divisor, fractional_part, sck_run} = {16'(d), 3'(f), s == USBRG_SRC_EXT};
        reset = 1'b1;
        @(negedge clk_sys);
        reset = 1'b0;
        repeat (n) exp_q.push_back(per);
        for (int i = 0; i < 3000 && (exp_q.size() > 0 || (n == 0 && i < 300)); i++)
            @(negedge clk_sys);
        reset = 1'b1;
        check(exp_q.size(), 0);
        exp_q.delete();
        $display("test done: source %0d divisor %0d period %0d", s, d, per);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // a frozen clock must not stretch the measured period
    always @(posedge clk_sys) begin
        if (reset) seen <= 0;
        else if (clk_en) begin
            gap <= baud_tick ? 1 : gap + 1;
            if (baud_tick && seen) check(gap, exp_q.size() ? exp_q.pop_front() : 0);
            if (baud_tick) seen <= 1;
        end
    end
    always @(negedge clk_sys) begin
        clk_en = !gate || ($urandom_range(0, 3) != 0);
        {rx_ready, dtr_assert, modem_present} = 3'($urandom);
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        summarize();
    end
    initial begin
        void'($urandom(32'h7fe479e0));
        {reset, clk_en, gate, sck_run, sync_mode, over} = 6'h30;
        {clock_source_select, channel_mode, clock_divisor, fractional_part} = '0;
        {rx_ready, dtr_assert, modem_present} = 3'h0;
        repeat (4) @(negedge clk_sys);
        run(USBRG_SRC_MCK, 0, 1, USBRG_MODE_NORMAL, 2, 0, 16, 4, 0);
        run(USBRG_SRC_MCK, 0, 0, USBRG_MODE_NORMAL, 3, 0, 48, 3, 0);
        run(USBRG_SRC_MCK, 0, 1, USBRG_MODE_NORMAL, 1, 0, 8, 4, 0);
        run(USBRG_SRC_MCK, 0, 1, USBRG_MODE_NORMAL, 0, 0, 0, 0, 0);
        run(USBRG_SRC_MCK, 0, 1, USBRG_MODE_NORMAL, 2, 3, 19, 4, 0);
        run(USBRG_SRC_MCK, 0, 1, USBRG_MODE_HWHS, 2, 3, 16, 3, 0);
        run(USBRG_SRC_MCK, 0, 1, USBRG_MODE_MODEM, 2, 5, 16, 3, 0);
        run(USBRG_SRC_DIV, 0, 1, USBRG_MODE_NORMAL, 1, 0, 64, 3, 0);
        run(2'h2, 0, 1, USBRG_MODE_NORMAL, 2, 0, 16, 3, 0);
        run(USBRG_SRC_DIV, 1, 0, USBRG_MODE_NORMAL, 2, 0, 16, 3, 0);
        run(USBRG_SRC_MCK, 1, 0, USBRG_MODE_NORMAL, 4, 5, 4, 4, 0);
        run(USBRG_SRC_EXT, 1, 0, USBRG_MODE_NORMAL, 7, 0, 10, 4, 0);
        run(USBRG_SRC_EXT, 0, 1, USBRG_MODE_NORMAL, 1, 0, 80, 3, 0);
        repeat (4) begin
            {cd, fp, ov} = {$urandom_range(2, 5), $urandom_range(0, 7), $urandom_range(0, 1)};
            run(USBRG_SRC_MCK, 0, ov, 0, cd, fp, 8 * (2 - ov) * cd + (2 - ov) * fp, 3, 1);
        end
        summarize();
    end
endmodule
